//--- hw/sysv_top.sv
// system supervisor: reset sequencing, watchdog, brown-out and tamper
//
// How it works
// - supply loss or power-up gives global clear
// - system clear spares clock settings and cause
// - watchdog, pin, debug command give system clear
// - cause register cleared only by power-up
// - core and io warnings raise brown-out interrupt
// - mask bits, when set, enable brown-out interrupts
// - core dropout always forces global clear
// - io threshold chosen by nonvolatile strap
// - firmware blocks io reset or disables monitor
// - 16-bit down-counter with 8-bit prescaler
// - enabled watchdog at terminal count resets
// - watchdog off after reset; free-run timer
// - long enough low pin pulse resets system
// - board reset output lasts power-on duration
// - hold until supplies good plus power-on time
// - debug-mode reset command gives system clear
// - tamper edge direction chosen by firmware
// - tamper captures time of day and date
// - tamper cuts sram standby supply at once
// - sram moves to backup when core drops, with monitor on
// - rtc setting picks backup for sram too
// - firmware resets any peripheral at will
module sysv_top #(
  parameter int NUM_PERIPH = 16,
  parameter int POR_TIME_NS = sysv_pkg::POR_TIME_NS,
  parameter int MIN_PULSE_NS = sysv_pkg::MIN_PULSE_NS
) (
  // clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply monitor comparators, high while below threshold, and io range strap
  input wire logic core_drop,
  input wire logic io_drop_low_range,
  input wire logic io_drop_high_range,
  input wire logic core_warn,
  input wire logic io_warn,
  input wire logic io_range_high_strap,
  // board and debug reset sources
  input wire logic board_reset_input_low,
  input wire logic jtag_debug_mode,
  input wire logic jtag_reset_cmd,
  // tamper and rtc
  input wire logic tamper_in,
  input wire logic [31:0] rtc_time,
  input wire logic [31:0] rtc_date,
  // reset and power outputs
  output logic global_clear,
  output logic system_clear,
  output logic board_reset_output_low,
  output logic brownout_irq,
  output logic sram_standby_en,
  output logic sram_on_backup,
  output logic rtc_backup_sram,
  output logic [NUM_PERIPH-1:0] periph_reset,
  output logic [31:0] clock_control_unit,
  output logic [31:0] boot_addr
);

  // ---------------------------------------------------------------
  // timing counts, least times rounded up
  // ---------------------------------------------------------------
  localparam int POR_CYC_I =
    (POR_TIME_NS + sysv_pkg::CLK_PERIOD_NS - 1) / sysv_pkg::CLK_PERIOD_NS;
  localparam int PULSE_CYC_I =
    (MIN_PULSE_NS + sysv_pkg::CLK_PERIOD_NS - 1) / sysv_pkg::CLK_PERIOD_NS;
  localparam logic [15:0] POR_CYC =
    16'(POR_CYC_I < 1 ? 1 : POR_CYC_I);
  localparam logic [15:0] PULSE_CYC =
    16'(PULSE_CYC_I < 1 ? 1 : PULSE_CYC_I);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sysv_pkg::sysv_state_t state_r;
  logic [15:0] seq_cnt_r;
  sysv_pkg::sysv_ctrl_t ctrl_r;
  sysv_pkg::sysv_warn_t mask_r;
  logic [3:0] cause_r;
  logic [31:0] clk_ctrl_r;
  sysv_pkg::sysv_wdctrl_t wdctrl_r;
  logic [15:0] wd_reload_r;
  logic [15:0] wd_cnt_r;
  logic [7:0] pre_cnt_r;
  logic [NUM_PERIPH-1:0] periph_r;
  logic range_high_r;
  logic pin_s1_r, pin_s2_r;
  logic [15:0] pin_cnt_r;
  logic tmp_s1_r, tmp_s2_r, tmp_prev_r;
  logic tamper_flag_r;
  logic sram_cut_r;
  logic [31:0] tmp_time_r, tmp_date_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic gclr, sclr;
  logic io_drop, gr_req, wd_fire, pin_fire, jtag_fire, sr_req;
  logic wd_tick, tamper_edge;
  logic wr_en, setup;
  logic [31:0] rd_mux;
  logic rd_hit;

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  // io threshold follows the strap captured during global clear
  assign io_drop = range_high_r ? io_drop_high_range
                                : io_drop_low_range;
  // core loss is never gated; io loss obeys monitor enable and block
  assign gr_req = core_drop
                | (ctrl_r.mon_en & ~ctrl_r.io_rst_block
                   & io_drop);
  assign jtag_fire = jtag_debug_mode & jtag_reset_cmd;
  assign pin_fire = (pin_cnt_r == PULSE_CYC);
  assign sr_req = wd_fire | pin_fire | jtag_fire;
  assign gclr = (state_r == sysv_pkg::ST_GLOBAL);
  assign sclr = (state_r != sysv_pkg::ST_RUN);

  // strap caught while global clear holds, so never under async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_high_r <= 1'b0;
    end else if (gclr) begin
      range_high_r <= io_range_high_strap;
    end
  end

  // board reset pin: two-flop synchroniser then low-time counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= board_reset_input_low;
      pin_s2_r <= pin_s1_r;
    end
  end

  // counts saturate one past the limit so a held pin fires once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt_r <= 16'h0000;
    end else if (pin_s2_r) begin
      pin_cnt_r <= 16'h0000;
    end else if (pin_cnt_r <= PULSE_CYC) begin
      pin_cnt_r <= pin_cnt_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  // global clear outranks everything; system clear only from run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= sysv_pkg::ST_GLOBAL;
      seq_cnt_r <= 16'h0000;
    end else if (gr_req) begin
      state_r <= sysv_pkg::ST_GLOBAL;
      seq_cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        sysv_pkg::ST_GLOBAL, sysv_pkg::ST_SYSTEM: begin
          if (seq_cnt_r == POR_CYC - 16'h0001) begin
            state_r <= sysv_pkg::ST_RUN;
            seq_cnt_r <= 16'h0000;
          end else begin
            seq_cnt_r <= seq_cnt_r + 16'h0001;
          end
        end
        sysv_pkg::ST_RUN: begin
          if (sr_req) begin
            state_r <= sysv_pkg::ST_SYSTEM;
          end
        end
        default: begin
          state_r <= sysv_pkg::ST_GLOBAL;
          seq_cnt_r <= 16'h0000;
        end
      endcase
    end
  end

  // cause of the last reset; only the power-up reset wipes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= 4'h0;
    end else if (gr_req && !gclr) begin
      cause_r <= 4'h0;
      cause_r[sysv_pkg::CAUSE_SUPPLY] <= 1'b1;
    end else if (state_r == sysv_pkg::ST_RUN && sr_req) begin
      cause_r <= 4'h0;
      cause_r[sysv_pkg::CAUSE_WDOG] <= wd_fire;
      cause_r[sysv_pkg::CAUSE_PIN] <= pin_fire;
      cause_r[sysv_pkg::CAUSE_JTAG] <= jtag_fire;
    end
  end

  // ---------------------------------------------------------------
  // apb slave, zero wait states, read data latched in setup
  // ---------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & ~sclr;

  // read mux over all words; unmapped offsets flag an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      sysv_pkg::OFF_CTRL: rd_mux[4:0] = ctrl_r;
      sysv_pkg::OFF_IRQ_MASK: rd_mux[1:0] = mask_r;
      sysv_pkg::OFF_CAUSE: rd_mux[3:0] = cause_r;
      sysv_pkg::OFF_CLK_CTRL: rd_mux = clk_ctrl_r;
      sysv_pkg::OFF_WD_CTRL: rd_mux[9:0] = wdctrl_r;
      sysv_pkg::OFF_WD_RELOAD: rd_mux[15:0] = wd_reload_r;
      sysv_pkg::OFF_WD_COUNT: rd_mux[15:0] = wd_cnt_r;
      sysv_pkg::OFF_PERIPH_RST: rd_mux[NUM_PERIPH-1:0] = periph_r;
      sysv_pkg::OFF_TAMPER_STAT: rd_mux[1:0] = {sram_cut_r, tamper_flag_r};
      sysv_pkg::OFF_TAMPER_TIME: rd_mux = tmp_time_r;
      sysv_pkg::OFF_TAMPER_DATE: rd_mux = tmp_date_r;
      sysv_pkg::OFF_STATUS: rd_mux[4:0] =
        {range_high_r, io_warn, core_warn, io_drop, core_drop};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~rd_hit;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;
  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // supervisor control and brown-out mask, cleared by system clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= sysv_pkg::CTRL_RST;
      mask_r <= sysv_pkg::MASK_RST;
    end else if (sclr) begin
      ctrl_r <= sysv_pkg::CTRL_RST;
      mask_r <= sysv_pkg::MASK_RST;
    end else if (wr_en && paddr == sysv_pkg::OFF_CTRL) begin
      ctrl_r <= pwdata[sysv_pkg::CTRL_W-1:0];
    end else if (wr_en && paddr == sysv_pkg::OFF_IRQ_MASK) begin
      mask_r <= pwdata[sysv_pkg::MASK_W-1:0];
    end
  end

  // clock settings survive system clear, lost only on global clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_r <= 32'h0000_0000;
    end else if (gclr) begin
      clk_ctrl_r <= 32'h0000_0000;
    end else if (wr_en && paddr == sysv_pkg::OFF_CLK_CTRL) begin
      clk_ctrl_r <= pwdata;
    end
  end

  // per-peripheral resets held while their bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_r <= '0;
    end else if (sclr) begin
      periph_r <= '0;
    end else if (wr_en && paddr == sysv_pkg::OFF_PERIPH_RST) begin
      periph_r <= pwdata[NUM_PERIPH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // watchdog / free-running timer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdctrl_r <= '0;
      wd_reload_r <= sysv_pkg::WD_RELOAD_RST;
    end else if (sclr) begin
      wdctrl_r <= '0;
      wd_reload_r <= sysv_pkg::WD_RELOAD_RST;
    end else if (wr_en && paddr == sysv_pkg::OFF_WD_CTRL) begin
      wdctrl_r <= pwdata[9:0];
    end else if (wr_en && paddr == sysv_pkg::OFF_WD_RELOAD) begin
      wd_reload_r <= pwdata[15:0];
    end
  end

  // prescaler divides pclk by prescale+1 into a tick enable
  assign wd_tick = (wdctrl_r.run | wdctrl_r.wd_en)
                 & (pre_cnt_r == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
    end else if (sclr || !(wdctrl_r.run || wdctrl_r.wd_en)) begin
      pre_cnt_r <= 8'h00;
    end else if (wd_tick) begin
      pre_cnt_r <= wdctrl_r.prescale;
    end else begin
      pre_cnt_r <= pre_cnt_r - 8'h01;
    end
  end

  // expiry only resets in watchdog mode; timer mode just reloads
  assign wd_fire = wdctrl_r.wd_en & wd_tick
                 & (wd_cnt_r == sysv_pkg::WD_TERMINAL);

  // writing the count word reloads, which is how firmware kicks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= sysv_pkg::WD_RELOAD_RST;
    end else if (sclr) begin
      wd_cnt_r <= sysv_pkg::WD_RELOAD_RST;
    end else if (wr_en && paddr == sysv_pkg::OFF_WD_COUNT) begin
      wd_cnt_r <= wd_reload_r;
    end else if (wd_tick) begin
      if (wd_cnt_r == sysv_pkg::WD_TERMINAL) begin
        wd_cnt_r <= wd_reload_r;
      end else begin
        wd_cnt_r <= wd_cnt_r - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // tamper detection
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_s1_r <= 1'b0;
      tmp_s2_r <= 1'b0;
      tmp_prev_r <= 1'b0;
    end else begin
      tmp_s1_r <= tamper_in;
      tmp_s2_r <= tmp_s1_r;
      tmp_prev_r <= tmp_s2_r;
    end
  end

  assign tamper_edge = ctrl_r.tamper_en & ~sclr
    & (ctrl_r.tamper_rise ? (tmp_s2_r & ~tmp_prev_r)
                          : (~tmp_s2_r & tmp_prev_r));

  // a new event beats a clear written in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tamper_flag_r <= 1'b0;
      sram_cut_r <= 1'b0;
    end else if (tamper_edge) begin
      tamper_flag_r <= 1'b1;
      sram_cut_r <= 1'b1;
    end else if (sclr) begin
      tamper_flag_r <= 1'b0;
      sram_cut_r <= 1'b0;
    end else if (wr_en && paddr == sysv_pkg::OFF_TAMPER_STAT
                 && pwdata[0]) begin
      tamper_flag_r <= 1'b0;
      sram_cut_r <= 1'b0;
    end
  end

  // time stamp taken in the same cycle as the supply cut
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_time_r <= 32'h0000_0000;
      tmp_date_r <= 32'h0000_0000;
    end else if (tamper_edge) begin
      tmp_time_r <= rtc_time;
      tmp_date_r <= rtc_date;
    end else if (sclr) begin
      tmp_time_r <= 32'h0000_0000;
      tmp_date_r <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign global_clear = gclr;
  assign system_clear = sclr;
  assign board_reset_output_low = ~sclr;
  // warnings are live levels, gated by monitor enable and mask
  assign brownout_irq = ctrl_r.mon_en
    & ((core_warn & mask_r.core_warn)
       | (io_warn & mask_r.io_warn));
  // switching to backup only works with the monitor running
  assign sram_on_backup = ctrl_r.mon_en & core_drop;
  assign sram_standby_en = ~sram_cut_r;
  assign rtc_backup_sram = ctrl_r.rtc_backup_sram & ~sram_cut_r;
  assign periph_reset = periph_r | {NUM_PERIPH{sclr}};
  assign clock_control_unit = clk_ctrl_r;
  assign boot_addr = sysv_pkg::BOOT_ADDR;

endmodule

//--- pkg/sysv_pkg.sv
// constants and types shared by the system supervisor block
package sysv_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFF_CAUSE = 8'h08;
  localparam logic [7:0] OFF_CLK_CTRL = 8'h0C;
  localparam logic [7:0] OFF_WD_CTRL = 8'h10;
  localparam logic [7:0] OFF_WD_RELOAD = 8'h14;
  localparam logic [7:0] OFF_WD_COUNT = 8'h18;
  localparam logic [7:0] OFF_PERIPH_RST = 8'h1C;
  localparam logic [7:0] OFF_TAMPER_STAT = 8'h20;
  localparam logic [7:0] OFF_TAMPER_TIME = 8'h24;
  localparam logic [7:0] OFF_TAMPER_DATE = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;

  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h01;     // monitor on
  localparam int MASK_W = 2;
  localparam logic [1:0] MASK_RST = 2'h0;      // warnings suppressed
  localparam int CAUSE_W = 4;
  localparam int CAUSE_SUPPLY = 0;
  localparam int CAUSE_WDOG = 1;
  localparam int CAUSE_PIN = 2;
  localparam int CAUSE_JTAG = 3;
  localparam int WD_W = 16;
  localparam int PRE_W = 8;
  localparam logic [15:0] WD_RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] WD_TERMINAL = 16'h0000;
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_TIME_NS = 10000;          // power-on hold time
  localparam int MIN_PULSE_NS = 1000;          // least valid pin pulse
  localparam int SEQ_W = 16;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_GLOBAL,
    ST_SYSTEM,
    ST_RUN
  } sysv_state_t;

  typedef struct packed {
    logic tamper_en;
    logic rtc_backup_sram;
    logic tamper_rise;
    logic io_rst_block;
    logic mon_en;
  } sysv_ctrl_t;

  typedef struct packed {
    logic [7:0] prescale;
    logic run;
    logic wd_en;
  } sysv_wdctrl_t;

  typedef struct packed {
    logic io_warn;
    logic core_warn;
  } sysv_warn_t;

endpackage

//--- testbench/sysv_top_bench.sv
// self-checking bench for the system supervisor
module sysv_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MIN_CYC = 5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_drop;
  logic io_drop_low_range, io_drop_high_range, core_warn, io_warn, e;
  logic io_range_high_strap, board_reset_input_low, jtag_debug_mode;
  logic jtag_reset_cmd, tamper_in, global_clear, system_clear;
  logic board_reset_output_low, brownout_irq, sram_standby_en;
  logic sram_on_backup, rtc_backup_sram;
  logic [7:0] paddr;
  logic [15:0] periph_reset;
  logic [31:0] pwdata, prdata, rtc_time, rtc_date, clock_control_unit;
  logic [31:0] boot_addr, v, q;
  int n_mismatch = 0;
  int checked = 0;
  // register reset values, modelled from the register layout
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1C, 8'h20};
  logic [31:0] rv [7] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000};
  sysv_top #(.POR_TIME_NS(1000), .MIN_PULSE_NS(500)) sysv_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_drop, .io_drop_low_range, .io_drop_high_range,
    .core_warn, .io_warn, .io_range_high_strap, .board_reset_input_low,
    .jtag_debug_mode, .jtag_reset_cmd, .tamper_in, .rtc_time, .rtc_date,
    .global_clear, .system_clear, .board_reset_output_low, .brownout_irq,
    .sram_standby_en, .sram_on_backup, .rtc_backup_sram, .periph_reset,
    .clock_control_unit, .boot_addr);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // idle cycle after release so no strobe is assigned twice in a step
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    cyc(1);
    while (pready !== 1'b1) cyc(1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input string nm);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, ex, q);
  endtask
  // a clear pulse must start soon, then end before writes resume
  task automatic wait_sys();
    int n;
    n = 0;
    while (system_clear !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("clear_seen", 32'h0000_0001, {31'h0, system_clear});
    while (system_clear !== 1'b0) cyc(1);
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // hang guard, far beyond the few hundred cycles of the sequence
  initial begin
    #3000000;
    n_mismatch++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(93097));
    {presetn, psel, penable, pwrite, core_drop, io_drop_low_range} = '0;
    {io_drop_high_range, core_warn, io_warn, io_range_high_strap} = '0;
    {jtag_debug_mode, jtag_reset_cmd, tamper_in} = '0;
    board_reset_input_low = 1'b1;
    {paddr, pwdata, rtc_time, rtc_date} = '0;
    cyc(6);
    presetn <= 1'b1;
    wait_sys();
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i], "reset_val");
    chk("boot", 32'h0000_0000, boot_addr);
    rd(8'h40, 32'h0000_0000, "unmapped_data");
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    apb(sysv_pkg::OFF_CAUSE, 1'b1, 32'hFFFF_FFFF);
    rd(sysv_pkg::OFF_CAUSE, 32'h0000_0000, "cause_ro");
    for (int i = 0; i < 2; i++) begin
      {io_warn, core_warn} <= 2'b01 << i;
      apb(sysv_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0000);
      chk("irq_masked", 32'h0000_0000, {31'h0, brownout_irq});
      apb(sysv_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0001 << i);
      chk("irq_raised", 32'h0000_0001, {31'h0, brownout_irq});
    end
    {io_warn, core_warn} <= 2'b00;
    v = $urandom;
    apb(sysv_pkg::OFF_CLK_CTRL, 1'b1, v);
    apb(sysv_pkg::OFF_PERIPH_RST, 1'b1, v);
    chk("periph", {16'h0, v[15:0]}, {16'h0, periph_reset});
    board_reset_input_low <= 1'b0;
    cyc(MIN_CYC - 3);
    board_reset_input_low <= 1'b1;
    cyc(8);
    chk("short_pulse", 32'h0000_0000, {31'h0, system_clear});
    board_reset_input_low <= 1'b0;
    cyc(MIN_CYC + 4);
    board_reset_input_low <= 1'b1;
    wait_sys();
    rd(sysv_pkg::OFF_CAUSE, 32'h0000_0004, "cause_pin");
    rd(sysv_pkg::OFF_CLK_CTRL, v, "clk_kept");
    chk("clk_unit", v, clock_control_unit);
    rd(sysv_pkg::OFF_PERIPH_RST, 32'h0000_0000, "periph_clr");
    for (int i = 0; i < 2; i++) begin
      jtag_debug_mode <= i[0];
      jtag_reset_cmd <= 1'b1;
      cyc(1);
      jtag_reset_cmd <= 1'b0;
      if (i == 0) begin
        cyc(8);
        chk("cmd_no_dbg", 32'h0000_0000, {31'h0, system_clear});
      end else begin
        wait_sys();
        rd(sysv_pkg::OFF_CAUSE, 32'h0000_0008, "cause_jtag");
      end
    end
    jtag_debug_mode <= 1'b0;
    // timer mode first: free running must never reset the system
    apb(sysv_pkg::OFF_WD_RELOAD, 1'b1, 32'h0000_0010);
    apb(sysv_pkg::OFF_WD_COUNT, 1'b1, 32'h0000_0000);
    apb(sysv_pkg::OFF_WD_CTRL, 1'b1, 32'h0000_0006);
    // first tick lands as the prescaler starts, next one two cycles on
    rd(sysv_pkg::OFF_WD_COUNT, 32'h0000_000F, "wd_count");
    cyc(60);
    chk("timer_mode", 32'h0000_0000, {31'h0, system_clear});
    apb(sysv_pkg::OFF_WD_CTRL, 1'b1, 32'h0000_0005);
    wait_sys();
    rd(sysv_pkg::OFF_CAUSE, 32'h0000_0002, "cause_wdog");
    rd(sysv_pkg::OFF_WD_CTRL, 32'h0000_0000, "wd_off");
    for (int i = 1; i >= 0; i--) begin
      v = $urandom;
      rtc_time <= v;
      rtc_date <= ~v;
      apb(sysv_pkg::OFF_CTRL, 1'b1, 32'h0000_0019 | (i << 2));
      tamper_in <= i[0];
      cyc(5);
      chk("sram_cut", 32'h0000_0000, {31'h0, sram_standby_en});
      chk("rtc_only", 32'h0000_0000, {31'h0, rtc_backup_sram});
      rd(sysv_pkg::OFF_TAMPER_STAT, 32'h0000_0003, "tamper_flag");
      rd(sysv_pkg::OFF_TAMPER_TIME, v, "tamper_time");
      rd(sysv_pkg::OFF_TAMPER_DATE, ~v, "tamper_date");
      apb(sysv_pkg::OFF_TAMPER_STAT, 1'b1, 32'h0000_0001);
      chk("sram_back", 32'h0000_0001, {31'h0, sram_standby_en});
      chk("rtc_sram", 32'h0000_0001, {31'h0, rtc_backup_sram});
    end
    for (int i = 1; i >= 0; i--) begin
      apb(sysv_pkg::OFF_CTRL, 1'b1, i);
      core_drop <= 1'b1;
      // look before the clear puts the monitor enable back on
      cyc(1);
      chk("sram_backup", i, {31'h0, sram_on_backup});
      cyc(2);
      chk("core_global", 32'h0000_0001, {31'h0, global_clear});
      core_drop <= 1'b0;
      wait_sys();
      rd(sysv_pkg::OFF_CAUSE, 32'h0000_0001, "cause_supply");
    end
    io_drop_high_range <= 1'b1;
    apb(sysv_pkg::OFF_CTRL, 1'b1, 32'h0000_0003);
    io_drop_low_range <= 1'b1;
    cyc(4);
    chk("io_blocked", 32'h0000_0000, {31'h0, system_clear});
    apb(sysv_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
    cyc(2);
    chk("io_low_trip", 32'h0000_0001, {31'h0, global_clear});
    {io_drop_low_range, io_drop_high_range, io_range_high_strap} <= 3'b001;
    wait_sys();
    io_drop_high_range <= 1'b1;
    cyc(3);
    chk("io_high_trip", 32'h0000_0001, {31'h0, global_clear});
    io_drop_high_range <= 1'b0;
    wait_sys();
    finish_test();
  end
endmodule
bind sysv_top sysv_top_sva #(.NUM_PERIPH(NUM_PERIPH),
  .POR_TIME_NS(POR_TIME_NS)) sysv_top_sva_inst (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .core_drop, .core_warn, .io_warn,
  .jtag_debug_mode, .jtag_reset_cmd, .global_clear, .system_clear,
  .board_reset_output_low, .brownout_irq, .sram_on_backup, .periph_reset,
  .boot_addr);

//--- testbench/sysv_top_sva.sv
// port-level assertion checker for the system supervisor
module sysv_top_sva #(
  parameter int NUM_PERIPH = 16,
  parameter int POR_TIME_NS = sysv_pkg::POR_TIME_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // reset and warning sources
  input wire logic core_drop,
  input wire logic core_warn,
  input wire logic io_warn,
  input wire logic jtag_debug_mode,
  input wire logic jtag_reset_cmd,
  // outputs
  input wire logic global_clear,
  input wire logic system_clear,
  input wire logic board_reset_output_low,
  input wire logic brownout_irq,
  input wire logic sram_on_backup,
  input wire logic [NUM_PERIPH-1:0] periph_reset,
  input wire logic [31:0] boot_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_CYC = POR_TIME_NS / sysv_pkg::CLK_PERIOD_NS;
  logic [15:0] hold_r;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // clear pulse length, so short pulses show as a count
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_r <= 16'h0000;
    else
      hold_r <= system_clear ? hold_r + 16'h0001 : 16'h0000;
  end
  AST_CORE_GLOBAL: assert property (core_drop |=> global_clear)
    else $error("core dropout gave no global clear");
  AST_GLOBAL_SYS: assert property (global_clear |-> system_clear)
    else $error("global clear without system clear");
  AST_OUT_PIN: assert property (board_reset_output_low == !system_clear)
    else $error("board reset output does not follow clear");
  AST_BOOT: assert property (boot_addr == sysv_pkg::BOOT_ADDR)
    else $error("boot address wrong");
  AST_BACKUP: assert property (sram_on_backup |-> core_drop)
    else $error("sram on backup without core drop");
  AST_IRQ_QUIET: assert property (!(core_warn || io_warn) |-> !brownout_irq)
    else $error("brown-out interrupt without warning");
  AST_PERIPH: assert property (system_clear |-> &periph_reset)
    else $error("peripheral not held in reset");
  AST_HOLD: assert property ($fell(system_clear) |-> hold_r >= POR_CYC)
    else $error("clear pulse shorter than power-on time");
  AST_SYS_HELD: assert property ($rose(system_clear) |=> system_clear[*8])
    else $error("system clear dropped early");
  AST_JTAG: assert property (jtag_debug_mode && jtag_reset_cmd && !system_clear
    |-> ##[1:2] system_clear)
    else $error("debug reset command ignored");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h2C |-> pslverr)
    else $error("unmapped access without error");
  C_FALL: cover property ($fell(system_clear));
  C_ERR: cover property (psel && penable && pslverr);
  C_IRQ: cover property (brownout_irq);
endmodule
